/* rtl/dcf_top.sv */
// Implementation choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
`include "dcf_params.svh"
// Behaviour
// - Full indication low at max count; writes ignored then; updated on write-clock edges only.
// - Empty indication low at zero count; reads ignored then; updated on read-clock edges only.
// - Sync flag mode: almost-full moves on write edges, almost-empty on read edges.
// - Replay pulse sends read pointer back to location zero for replaying data.
// - Full clears on the write edge after a read, else one write cycle later.
// - Empty clears on the read edge after a write, else one cycle later.
// - After reset data outputs are zero when enabled and released when not.
// - Free-running clocks during reset are tolerated; edges are ignored meanwhile.
// - First stored word can be read the read cycle after empty clears.
// - First-word latency at empty is one or two read periods plus skew.
// - A read dropping almost-empty leaves empty offset words.
// - A write dropping almost-full leaves full offset words free.
// - Sync mode: a write moves almost-empty on a later read edge.
// - Sync mode: a read moves almost-full on a later write edge.
// - Async mode: almost flags held invalid for a settle time after offset write.
// - Flags may move during replay; valid only after the recovery time.
// - Sync mode almost flags refresh after recovery on the next suitable edge.
module dcf_top
    import dcf_pkg::*;
#(
    parameter int DEPTH = 8192
)
(
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    // Writer pins
    input wire logic i_wclk,
    input wire logic i_wen_n,
    input wire logic [17:0] i_data,
    // Reader pins
    input wire logic i_rclk,
    input wire logic i_ren_n,
    input wire logic i_oe_n,
    output logic [17:0] o_q,
    output logic o_q_oe,
    // Control pins
    input wire logic i_reset_pulse_n,
    input wire logic i_replay_pulse,
    input wire logic i_flag_sync_select_n,
    // Flags, all active low
    output dcf_flags_s o_flags,
    // Interrupt
    output logic o_irq,
    // AXI4-Lite slave
    input wire logic [7:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [7:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready
);

    localparam int AW = $clog2(DEPTH);
    localparam int PW = AW + 1;
    localparam logic [31:0] DEPTH_W = 32'(DEPTH);
    localparam logic [4:0] RTR_CYC = 5'(`DCF_RTR_CYC);
    localparam logic [3:0] SETTLE_CYC = 4'(`DCF_SETTLE_CYC);

    if (DEPTH < 4 || DEPTH > (1 << 22) || (DEPTH & (DEPTH - 1)) != 0)
    begin : g_chk
        $error("DEPTH must be a power of two from 4 to 4M");
    end

    typedef struct packed {
        logic [PW-1:0] wptr;
        logic [PW-1:0] rptr;
        logic [PW-1:0] rptr_w;
        logic [PW-1:0] wptr_r;
        dcf_flags_s flags;
        logic [17:0] q;
        logic q_oe;
        logic [15:0] ofs_e;
        logic [15:0] ofs_f;
        logic [3:0] irq_stat;
        logic [3:0] irq_mask;
        logic irq;
        logic [3:0] settle;
        logic [4:0] rtr;
    } dcf_state_s;

    localparam dcf_flags_s FLAGS_RST = '{full_n: 1'b1, empty_n: 1'b0, afull_n: 1'b1, aempty_n: 1'b0,
                                         half_n: 1'b1};

    dcf_state_s q;
    dcf_state_s d;
    logic [17:0] mem [DEPTH];
    logic mem_we;
    logic [`DCF_PIN_W-1:0] pin_lvl;
    logic [`DCF_PIN_W-1:0] pin_rise;
    dcf_regwr_s wr;
    logic [7:0] rd_addr;
    logic [31:0] rd_data;
    logic fifo_rst;
    logic sync_mode;
    logic [PW-1:0] wcnt;
    logic [PW-1:0] rcnt;
    logic [PW-1:0] tcnt;
    logic [31:0] wr_val;
    logic [3:0] ev;

    dcf_pin_sync #(
        .W(`DCF_PIN_W),
        .RST_VAL(`DCF_PIN_RST_VAL)
    ) u_pins (
        .i_mclk(i_mclk),
        .i_sys_rst(i_sys_rst),
        .i_pin({i_data, i_flag_sync_select_n, i_replay_pulse, i_reset_pulse_n, i_oe_n, i_ren_n, i_wen_n,
                i_rclk, i_wclk}),
        .o_lvl(pin_lvl),
        .o_rise(pin_rise)
    );

    dcf_axil u_bus (
        .i_mclk(i_mclk),
        .i_sys_rst(i_sys_rst),
        .i_awaddr(i_awaddr),
        .i_awvalid(i_awvalid),
        .o_awready(o_awready),
        .i_wdata(i_wdata),
        .i_wstrb(i_wstrb),
        .i_wvalid(i_wvalid),
        .o_wready(o_wready),
        .o_bresp(o_bresp),
        .o_bvalid(o_bvalid),
        .i_bready(i_bready),
        .i_araddr(i_araddr),
        .i_arvalid(i_arvalid),
        .o_arready(o_arready),
        .o_rdata(o_rdata),
        .o_rresp(o_rresp),
        .o_rvalid(o_rvalid),
        .i_rready(i_rready),
        .o_wr(wr),
        .o_rd_addr(rd_addr),
        .i_rd_data(rd_data)
    );

    // Pin reset acts with the clocks still running; their edges are simply not used
    assign fifo_rst = ~pin_lvl[`DCF_PIN_RST_N];
    assign sync_mode = ~pin_lvl[`DCF_PIN_SYNC_N];

    always_comb
    begin
        d = q;
        mem_we = 1'b0;
        ev = '0;
        wr_val = '0;
        // One register stage per crossing keeps the added lag to a single cycle
        d.rptr_w = q.rptr;
        d.wptr_r = q.wptr;
        d.q_oe = ~pin_lvl[`DCF_PIN_OE_N];
        wcnt = PW'(q.wptr - q.rptr_w);
        rcnt = PW'(q.wptr_r - q.rptr);
        tcnt = PW'(q.wptr - q.rptr);
        if (q.rtr != 5'h00)
        begin
            d.rtr = q.rtr - 5'h01;
        end
        if (q.settle != 4'h0)
        begin
            d.settle = q.settle - 4'h1;
        end
        if (fifo_rst)
        begin
            d.wptr = '0;
            d.rptr = '0;
            d.rptr_w = '0;
            d.wptr_r = '0;
            d.flags = FLAGS_RST;
            d.q = '0;
            d.rtr = 5'h00;
        end
        else
        begin
            if (pin_rise[`DCF_PIN_WCLK])
            begin
                if (!pin_lvl[`DCF_PIN_WEN_N])
                begin
                    if (q.flags.full_n)
                    begin
                        mem_we = 1'b1;
                        d.wptr = PW'(q.wptr + 1'b1);
                    end
                    else
                    begin
                        ev[`DCF_EV_WR_REFUSED] = 1'b1;
                    end
                end
                wcnt = PW'(d.wptr - q.rptr_w);
                // A read seen in the copied pointer frees the flag at this write edge
                d.flags.full_n = (32'(wcnt) != DEPTH_W);
                if (sync_mode)
                begin
                    d.flags.afull_n = (32'(wcnt) + 32'(q.ofs_f) < DEPTH_W);
                end
            end
            if (pin_rise[`DCF_PIN_RCLK])
            begin
                if (!pin_lvl[`DCF_PIN_REN_N])
                begin
                    if (q.flags.empty_n)
                    begin
                        d.q = mem[q.rptr[AW-1:0]];
                        d.rptr = PW'(q.rptr + 1'b1);
                    end
                    else
                    begin
                        ev[`DCF_EV_RD_REFUSED] = 1'b1;
                    end
                end
                rcnt = PW'(q.wptr_r - d.rptr);
                d.flags.empty_n = (rcnt != '0);
                if (sync_mode)
                begin
                    d.flags.aempty_n = (32'(rcnt) > 32'(q.ofs_e));
                end
            end
            // Replay overrides a read in the same cycle
            if (pin_rise[`DCF_PIN_REPLAY])
            begin
                d.rptr = '0;
                d.rtr = RTR_CYC;
            end
            tcnt = PW'(d.wptr - d.rptr);
            // Async flags track the true fill every cycle but freeze while offsets settle
            if (!sync_mode && q.settle == 4'h0)
            begin
                d.flags.afull_n = (32'(tcnt) + 32'(q.ofs_f) < DEPTH_W);
                d.flags.aempty_n = (32'(tcnt) > 32'(q.ofs_e));
            end
            d.flags.half_n = (32'(tcnt) <= (DEPTH_W >> 1));
        end
        ev[`DCF_EV_AFULL] = q.flags.afull_n & ~d.flags.afull_n;
        ev[`DCF_EV_AEMPTY] = q.flags.aempty_n & ~d.flags.aempty_n;
        if (wr.en)
        begin
            case (wr.addr)
                `DCF_ADDR_EMPTY_OFS:
                begin
                    wr_val = dcf_apply_strb({16'h0000, q.ofs_e}, wr.data, wr.strb);
                    d.ofs_e = wr_val[15:0];
                    d.settle = SETTLE_CYC;
                end
                `DCF_ADDR_FULL_OFS:
                begin
                    wr_val = dcf_apply_strb({16'h0000, q.ofs_f}, wr.data, wr.strb);
                    d.ofs_f = wr_val[15:0];
                    d.settle = SETTLE_CYC;
                end
                `DCF_ADDR_IRQ_STAT:
                begin
                    wr_val = dcf_apply_strb(32'h00000000, wr.data, wr.strb);
                    d.irq_stat = q.irq_stat & ~wr_val[3:0];
                end
                `DCF_ADDR_IRQ_MASK:
                begin
                    wr_val = dcf_apply_strb({28'h0000000, q.irq_mask}, wr.data, wr.strb);
                    d.irq_mask = wr_val[3:0];
                end
                default:
                begin
                    wr_val = '0;
                end
            endcase
        end
        // New events win over a clear in the same cycle
        d.irq_stat = d.irq_stat | ev;
        d.irq = |(d.irq_stat & d.irq_mask);
    end

    always_comb
    begin
        rd_data = '0;
        case (rd_addr)
            `DCF_ADDR_STATUS:
            begin
                rd_data[`DCF_ST_FULL_N] = q.flags.full_n;
                rd_data[`DCF_ST_EMPTY_N] = q.flags.empty_n;
                rd_data[`DCF_ST_AFULL_N] = q.flags.afull_n;
                rd_data[`DCF_ST_AEMPTY_N] = q.flags.aempty_n;
                rd_data[`DCF_ST_HALF_N] = q.flags.half_n;
                rd_data[`DCF_ST_ALMOST_OK] = (q.settle == 4'h0) && (q.rtr == 5'h00);
                rd_data[`DCF_ST_REPLAY] = (q.rtr != 5'h00);
                rd_data[`DCF_ST_SYNC_MODE] = sync_mode;
                rd_data[`DCF_ST_FILL +: PW] = PW'(q.wptr - q.rptr);
            end
            `DCF_ADDR_EMPTY_OFS:
            begin
                rd_data[15:0] = q.ofs_e;
            end
            `DCF_ADDR_FULL_OFS:
            begin
                rd_data[15:0] = q.ofs_f;
            end
            `DCF_ADDR_IRQ_STAT:
            begin
                rd_data[3:0] = q.irq_stat;
            end
            `DCF_ADDR_IRQ_MASK:
            begin
                rd_data[3:0] = q.irq_mask;
            end
            `DCF_ADDR_LEVELS:
            begin
                rd_data[15:0] = 16'(q.wptr[AW-1:0]);
                rd_data[31:16] = 16'(q.rptr[AW-1:0]);
            end
            default:
            begin
                rd_data = '0;
            end
        endcase
    end

    // Storage has no reset; pointers alone define what is valid
    always_ff @(posedge i_mclk)
    begin
        if (mem_we)
        begin
            mem[q.wptr[AW-1:0]] <= pin_lvl[`DCF_PIN_DATA +: 18];
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst)
        begin
            q <= '0;
            q.flags <= FLAGS_RST;
            q.ofs_e <= `DCF_DEF_OFS;
            q.ofs_f <= `DCF_DEF_OFS;
            q.irq_mask <= `DCF_IRQ_MASK_RST;
        end
        else
        begin
            q <= d;
        end
    end

    assign o_q = q.q;
    assign o_q_oe = q.q_oe;
    assign o_flags = q.flags;
    assign o_irq = q.irq;

endmodule

/* rtl/dcf_params.svh */
`ifndef DCF_PARAMS_SVH
`define DCF_PARAMS_SVH

// Core clock and timing figures, in ns as printed
`define DCF_CLK_NS 5
`define DCF_RTR_NS 90
`define DCF_OFS_SETTLE_NS 5
`define DCF_ASYNC_FLAG_NS 15
`define DCF_FULL_SKEW_NS 5
`define DCF_EMPTY_SKEW_NS 5
`define DCF_ALMOST_SKEW_NS 10

// Least times round up to whole core cycles
`define DCF_RTR_CYC ((`DCF_RTR_NS + `DCF_CLK_NS - 1) / `DCF_CLK_NS)
`define DCF_SETTLE_CYC ((`DCF_OFS_SETTLE_NS + `DCF_ASYNC_FLAG_NS + `DCF_CLK_NS - 1) / `DCF_CLK_NS)

// Register byte addresses
`define DCF_ADDR_STATUS 8'h00
`define DCF_ADDR_EMPTY_OFS 8'h04
`define DCF_ADDR_FULL_OFS 8'h08
`define DCF_ADDR_IRQ_STAT 8'h0c
`define DCF_ADDR_IRQ_MASK 8'h10
`define DCF_ADDR_LEVELS 8'h14

// Reset values
`define DCF_DEF_OFS 16'h007f
`define DCF_IRQ_MASK_RST 4'h0

// Status register fields
`define DCF_ST_FULL_N 0
`define DCF_ST_EMPTY_N 1
`define DCF_ST_AFULL_N 2
`define DCF_ST_AEMPTY_N 3
`define DCF_ST_HALF_N 4
`define DCF_ST_ALMOST_OK 5
`define DCF_ST_REPLAY 6
`define DCF_ST_SYNC_MODE 7
`define DCF_ST_FILL 8

// Interrupt event bits
`define DCF_EV_WR_REFUSED 0
`define DCF_EV_RD_REFUSED 1
`define DCF_EV_AFULL 2
`define DCF_EV_AEMPTY 3

// Sampled pin positions
`define DCF_PIN_WCLK 0
`define DCF_PIN_RCLK 1
`define DCF_PIN_WEN_N 2
`define DCF_PIN_REN_N 3
`define DCF_PIN_OE_N 4
`define DCF_PIN_RST_N 5
`define DCF_PIN_REPLAY 6
`define DCF_PIN_SYNC_N 7
`define DCF_PIN_DATA 8
`define DCF_PIN_W 26
`define DCF_PIN_RST_VAL 26'h00000bc

// Bus responses
`define DCF_RESP_OKAY 2'b00
`define DCF_RESP_SLVERR 2'b10

`endif

/* rtl/dcf_pkg.sv */
package dcf_pkg;

    typedef struct packed {
        logic full_n;
        logic empty_n;
        logic afull_n;
        logic aempty_n;
        logic half_n;
    } dcf_flags_s;

    typedef struct packed {
        logic en;
        logic [7:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } dcf_regwr_s;

    function automatic logic [31:0] dcf_apply_strb(input logic [31:0] old_v, input logic [31:0] new_v,
                                                   input logic [3:0] strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

endpackage

/* rtl/dcf_pin_sync.sv */
`timescale 1ns/10ps
module dcf_pin_sync
    import dcf_pkg::*;
#(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
)
(
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    // Pins
    input wire logic [W-1:0] i_pin,
    // Settled levels and rising changes
    output logic [W-1:0] o_lvl,
    output logic [W-1:0] o_rise
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
    } dcf_sync_s;

    dcf_sync_s q;
    dcf_sync_s d;

    // A change counts only once stages two and three agree
    always_comb
    begin
        d = q;
        d.s1 = i_pin;
        d.s2 = q.s1;
        d.s3 = q.s2;
        for (int i = 0; i < W; i++)
        begin
            if (q.s2[i] == q.s3[i])
            begin
                d.lvl[i] = q.s3[i];
            end
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst)
        begin
            q <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, lvl: RST_VAL};
        end
        else
        begin
            q <= d;
        end
    end

    assign o_lvl = q.lvl;
    assign o_rise = q.s2 & q.s3 & ~q.lvl;

endmodule

/* rtl/dcf_axil.sv */
`timescale 1ns/10ps
`include "dcf_params.svh"
module dcf_axil
    import dcf_pkg::*;
(
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    // AXI4-Lite slave
    input wire logic [7:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [7:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    // Register side
    output dcf_regwr_s o_wr,
    output logic [7:0] o_rd_addr,
    input wire logic [31:0] i_rd_data
);

    typedef struct packed {
        logic awready;
        logic wready;
        logic arready;
        logic rd_pend;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [7:0] ar_addr;
        dcf_regwr_s wr;
    } dcf_bus_s;

    dcf_bus_s q;
    dcf_bus_s d;

    function automatic logic addr_ok(input logic [7:0] a);
        return (a == `DCF_ADDR_STATUS) || (a == `DCF_ADDR_EMPTY_OFS) || (a == `DCF_ADDR_FULL_OFS) ||
               (a == `DCF_ADDR_IRQ_STAT) || (a == `DCF_ADDR_IRQ_MASK) || (a == `DCF_ADDR_LEVELS);
    endfunction

    always_comb
    begin
        d = q;
        d.wr.en = 1'b0;
        if (q.awready && i_awvalid)
        begin
            d.awready = 1'b0;
            d.wr.addr = i_awaddr;
        end
        if (q.wready && i_wvalid)
        begin
            d.wready = 1'b0;
            d.wr.data = i_wdata;
            d.wr.strb = i_wstrb;
        end
        // Address and data both held: one write pulse if the address is mapped, raised together with the response
        if (!q.awready && !q.wready && !q.bvalid)
        begin
            d.wr.en = addr_ok(q.wr.addr);
            d.bvalid = 1'b1;
            d.bresp = addr_ok(q.wr.addr) ? `DCF_RESP_OKAY : `DCF_RESP_SLVERR;
        end
        if (q.bvalid && i_bready)
        begin
            d.bvalid = 1'b0;
            d.awready = 1'b1;
            d.wready = 1'b1;
        end
        if (q.arready && i_arvalid)
        begin
            d.arready = 1'b0;
            d.rd_pend = 1'b1;
            d.ar_addr = i_araddr;
        end
        if (q.rd_pend)
        begin
            d.rd_pend = 1'b0;
            d.rvalid = 1'b1;
            d.rdata = addr_ok(q.ar_addr) ? i_rd_data : 32'h00000000;
            d.rresp = addr_ok(q.ar_addr) ? `DCF_RESP_OKAY : `DCF_RESP_SLVERR;
        end
        if (q.rvalid && i_rready)
        begin
            d.rvalid = 1'b0;
            d.arready = 1'b1;
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_sys_rst)
        begin
            q <= '0;
            q.awready <= 1'b1;
            q.wready <= 1'b1;
            q.arready <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    assign o_awready = q.awready;
    assign o_wready = q.wready;
    assign o_bvalid = q.bvalid;
    assign o_bresp = q.bresp;
    assign o_arready = q.arready;
    assign o_rvalid = q.rvalid;
    assign o_rdata = q.rdata;
    assign o_rresp = q.rresp;
    assign o_wr = q.wr;
    assign o_rd_addr = q.ar_addr;

endmodule

/* test/dcf_top_props.sv */
`timescale 1ns/10ps
`include "dcf_params.svh"
module dcf_top_props
    import dcf_pkg::*;
(
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    // Pins
    input wire logic i_oe_n,
    input wire logic i_reset_pulse_n,
    input wire logic [17:0] o_q,
    input wire logic o_q_oe,
    input wire dcf_flags_s o_flags,
    input wire logic o_irq,
    // Bus
    input wire logic [7:0] i_awaddr,
    input wire logic i_awvalid,
    input wire logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    input wire logic o_wready,
    input wire logic [1:0] o_bresp,
    input wire logic o_bvalid,
    input wire logic i_bready,
    input wire logic [7:0] i_araddr,
    input wire logic i_arvalid,
    input wire logic o_arready,
    input wire logic [31:0] o_rdata,
    input wire logic [1:0] o_rresp,
    input wire logic o_rvalid,
    input wire logic i_rready
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);
    sequence wr_take;
        i_awvalid && o_awready && i_wvalid && o_wready;
    endsequence
    sequence rd_take;
        i_arvalid && o_arready;
    endsequence
    wr_resp_a: assert property (wr_take |-> ##2 o_bvalid)
        else $error("write response not on time");
    rd_resp_a: assert property (rd_take |-> ##2 o_rvalid)
        else $error("read response not on time");
    b_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
        else $error("write response dropped");
    r_hold_a: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
        else $error("read response dropped");
    bad_addr_a: assert property ((rd_take and (i_araddr > 8'h14))
        |-> ##2 o_rresp == `DCF_RESP_SLVERR && o_rdata == 32'h0)
        else $error("unmapped read not refused");
    // Generous margin: mask and irq flop land together, one cycle after bvalid
    mask_off_a: assert property ((wr_take and (i_awaddr == `DCF_ADDR_IRQ_MASK && i_wdata[3:0] == 4'h0 && i_wstrb[0]))
        |-> ##5 !o_irq) else $error("masked interrupt still high");
    rst_flags_a: assert property ($fell(i_sys_rst) |-> o_flags == 5'b10101 && o_q == 18'h0)
        else $error("reset flag values wrong");
    dev_rst_a: assert property (!i_reset_pulse_n [*7] |-> !o_flags.empty_n && o_q == 18'h0)
        else $error("device reset not applied");
    oe_on_a: assert property (!i_oe_n [*8] |-> o_q_oe)
        else $error("output not driven");
    oe_off_a: assert property (i_oe_n [*8] |-> !o_q_oe)
        else $error("output not released");
    full_empty_a: assert property (!o_flags.full_n |-> o_flags.empty_n)
        else $error("full and empty together");
endmodule
bind dcf_top dcf_top_props u_props (.*);

/* test/dcf_pin_agent.sv */
`timescale 1ns/10ps
module dcf_pin_agent
(
    // Pins toward the buffer
    output logic o_wclk,
    output logic o_rclk,
    output logic o_wen_n,
    output logic o_ren_n,
    output logic [17:0] o_data
);
    // Clocks free-run, also through resets
    initial
    begin
        o_wclk = 0;
        forever #20 o_wclk = ~o_wclk;
    end
    initial
    begin
        o_rclk = 0;
        forever #25 o_rclk = ~o_rclk;
    end
    initial
    begin
        o_wen_n = 1;
        o_ren_n = 1;
        o_data = 18'h0;
    end
    // Enables move on falling edges, far from the sampled rise
    task put(input logic [17:0] d);
        @(negedge o_wclk);
        o_wen_n = 0;
        o_data = d;
        @(negedge o_wclk);
        o_wen_n = 1;
        o_data = ~d;
    endtask
    task take;
        @(negedge o_rclk);
        o_ren_n = 0;
        @(negedge o_rclk);
        o_ren_n = 1;
    endtask
endmodule

/* test/dcf_top_tb.sv */
`timescale 1ns/10ps
`include "dcf_params.svh"
module dcf_top_tb
    import dcf_pkg::*;
;
    localparam int DEPTH = 16;
    logic i_mclk, i_sys_rst, i_oe_n, i_reset_pulse_n, i_replay_pulse, i_flag_sync_select_n;
    logic i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
    logic [7:0] i_awaddr, i_araddr;
    logic [31:0] i_wdata, o_rdata;
    logic [3:0] i_wstrb;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_q_oe, o_irq;
    logic [1:0] o_bresp, o_rresp;
    logic [17:0] o_q, i_data, d;
    logic i_wclk, i_rclk, i_wen_n, i_ren_n;
    dcf_flags_s o_flags;
    logic [33:0] exp_q[$], msk_q[$];
    logic [17:0] ref_q[$];
    int n_errors, checks, seed;

    dcf_top #(.DEPTH(DEPTH)) dut (.*);
    dcf_pin_agent agent (.o_wclk(i_wclk), .o_rclk(i_rclk), .o_wen_n(i_wen_n), .o_ren_n(i_ren_n), .o_data(i_data));

    initial
    begin
        i_mclk = 0;
        forever #2.5 i_mclk = ~i_mclk;
    end

    task chk(input string nm, input logic [33:0] e, input logic [33:0] s);
        checks++;
        if (s !== e)
        begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask

    task axw(input logic [7:0] a, input logic [31:0] v);
        bit done;
        // Static task: the flag must be cleared on every call, not only once
        done = 0;
        @(posedge i_mclk);
        i_awaddr <= a;
        i_wdata <= v;
        i_awvalid <= 1;
        i_wvalid <= 1;
        i_bready <= 1;
        while (!done)
        begin
            @(posedge i_mclk);
            if (o_awready) i_awvalid <= 0;
            if (o_wready) i_wvalid <= 0;
            done = o_bvalid;
        end
        i_bready <= 0;
    endtask

    task axr(input logic [7:0] a, input logic [33:0] e, input logic [33:0] m);
        bit done;
        done = 0;
        exp_q.push_back(e);
        msk_q.push_back(m);
        @(posedge i_mclk);
        i_araddr <= a;
        i_arvalid <= 1;
        i_rready <= 1;
        while (!done)
        begin
            @(posedge i_mclk);
            if (o_arready) i_arvalid <= 0;
            done = o_rvalid;
        end
        i_rready <= 0;
    endtask

    // Second process: each read answer against the oldest note
    always @(posedge i_mclk)
        if (o_rvalid && i_rready) chk("rdata", exp_q.pop_front(), {o_rresp, o_rdata} & msk_q.pop_front());

    task rd_word(input logic [17:0] e);
        agent.take();
        repeat (6) @(posedge i_mclk);
        chk("q", {16'h0, e}, {16'h0, o_q});
    endtask

    task print_verdict;
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    initial
    begin
        #50us;
        n_errors++;
        $display("watchdog expired");
        print_verdict();
    end

    initial
    begin
        seed = 18;
        {i_awaddr, i_araddr, i_wdata, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = '0;
        {i_replay_pulse, i_flag_sync_select_n, i_oe_n} = '0;
        i_wstrb = 4'hf;
        i_reset_pulse_n = 1;
        i_sys_rst = 1;
        repeat (3) @(posedge i_mclk);
        i_sys_rst <= 0;
        // Default full offset is above the test depth, so almost full already stands low
        axr(`DCF_ADDR_STATUS, 34'h11, 34'h3_0000_001f);
        axr(`DCF_ADDR_EMPTY_OFS, 34'h7f, '1);
        axr(`DCF_ADDR_FULL_OFS, 34'h7f, '1);
        axr(`DCF_ADDR_IRQ_MASK, 34'h0, '1);
        axr(8'h40, {`DCF_RESP_SLVERR, 32'h0}, '1);
        chk("q_oe", 34'h1, {33'h0, o_q_oe});
        $display("test reset done");
        axw(`DCF_ADDR_EMPTY_OFS, 32'h2);
        axw(`DCF_ADDR_FULL_OFS, 32'h3);
        axw(`DCF_ADDR_IRQ_MASK, 32'hf);
        // One word beyond depth must be refused
        for (int i = 0; i <= DEPTH; i++)
        begin
            d = 18'($random(seed));
            if (i < DEPTH) ref_q.push_back(d);
            agent.put(d);
        end
        repeat (8) @(posedge i_mclk);
        axr(`DCF_ADDR_STATUS, 34'h0a, 34'h3_0000_001f);
        axr(`DCF_ADDR_IRQ_STAT, 34'h5, 34'h3_0000_0005);
        chk("irq", 34'h1, {33'h0, o_irq});
        $display("test fill done");
        rd_word(ref_q[0]);
        axr(`DCF_ADDR_STATUS, 34'h1, 34'h3_0000_0001);
        for (int i = 1; i < DEPTH; i++) rd_word(ref_q[i]);
        rd_word(ref_q[DEPTH-1]);
        axr(`DCF_ADDR_STATUS, 34'h15, 34'h3_0000_001f);
        axr(`DCF_ADDR_IRQ_STAT, 34'ha, 34'h3_0000_000a);
        axw(`DCF_ADDR_IRQ_STAT, 32'hf);
        axr(`DCF_ADDR_IRQ_STAT, 34'h0, 34'h3_0000_000f);
        chk("irq", 34'h0, {33'h0, o_irq});
        $display("test drain done");
        ref_q.delete();
        i_reset_pulse_n <= 0;
        repeat (8) @(posedge i_mclk);
        i_reset_pulse_n <= 1;
        chk("q", 34'h0, {16'h0, o_q});
        repeat (8) @(posedge i_mclk);
        for (int i = 0; i < 4; i++)
        begin
            d = 18'($random(seed));
            ref_q.push_back(d);
            agent.put(d);
        end
        wait (o_flags.empty_n === 1'b1);
        rd_word(ref_q[0]);
        rd_word(ref_q[1]);
        @(posedge i_mclk);
        i_replay_pulse <= 1;
        repeat (12) @(posedge i_mclk);
        i_replay_pulse <= 0;
        // Flags are not trusted until recovery has passed
        repeat (20) @(posedge i_mclk);
        for (int i = 0; i < 4; i++) rd_word(ref_q[i]);
        $display("test replay done");
        axw(`DCF_ADDR_IRQ_MASK, 32'h0);
        @(posedge i_mclk);
        i_oe_n <= 1;
        repeat (8) @(posedge i_mclk);
        chk("q_oe", 34'h0, {33'h0, o_q_oe});
        $display("test output enable done");
        print_verdict();
    end
endmodule
